// File: hdl/pic_map.vh
// Constants for the priority interrupt channel block
`ifndef PIC_MAP_VH
`define PIC_MAP_VH

`define PIC_NCH 4
`define PIC_CH_BASE 14'h001e
`define PIC_AW 14

`define PIC_SYNC_W 3

`define PIC_OFF_CTRL 8'h00
`define PIC_OFF_STATE 8'h04
`define PIC_OFF_STAT 8'h08
`define PIC_OFF_MASK 8'h0c
`define PIC_OFF_SAFE 8'h10
`define PIC_OFF_GRANT 8'h14

`define PIC_CTRL_EN_BIT 0
`define PIC_CTRL_RST 1'b0
`define PIC_MASK_RST 3'h0
`define PIC_SAFE_RST 4'h1

`define PIC_ST_GRANT 0
`define PIC_ST_RETURN 1
`define PIC_ST_REJECT 2
`define PIC_ST_W 3

`define PIC_EOM_DISABLE 14'h0e02
`define PIC_EOM_ENABLE 14'h0e04

`define PIC_HTRANS_NONSEQ 2'h2
`define PIC_HRESP_OKAY 1'b0

`endif

// File: hdl/pic_channels.v
// Fixed-priority vectored interrupt channels with AHB-Lite register slave
//
// Behaviour
// R1: Each channel keeps request-received and in-service flags: inactive/wait/active.
// R2: In-service never set without request-received; both always clear together.
// R3: Waiting holds under higher service, long operation, or system disabled.
// R4: A short request pulse is latched and held until serviced. The synchronizer drops a pulse that stands less than two clocks.
// R5: On re-enable, all waiting channels are serviced in priority order.
// R6: Higher request preempts an active channel; preempted stays active, nesting.
// R7: After nested service, intermediate waiting ones are serviced before preempted resumes.
// R8: Requests on an active channel are ignored until it is cleared.
// R9: START forces every channel inactive.
// R10: Energize-output disables system; power-safety channels stay enabled.
// R11: Grant at instruction boundary; core executes word at channel-number address.
// R12: Forced fetch leaves program counter unchanged, like execute-indirect.
// R13: Return branch clears highest-priority active channel; software ends so.
// R14: Lower channel number means higher priority.
// R15: Channels 30 and 31 present; 32, 33 with second buffer.
// R16: Software puts mark-place-and-branch at each channel location.
// R17: Grant lowest waiting channel only if below every active one, enabled.
`timescale 1ns/1ps
`include "pic_map.vh"

module pic_channels (
  clk,
  rst_n,
  start,
  chan_req,
  instr_boundary,
  long_op_busy,
  unconditional_branch_op,
  energize_output_op,
  eom_addr,
  force_valid,
  force_addr,
  pc_hold,
  hsel,
  haddr,
  htrans,
  hwrite,
  hsize,
  hwdata,
  hready,
  hreadyout,
  hresp,
  hrdata,
  irq
);
  input wire clk;
  input wire rst_n;
  input wire start;
  input wire [`PIC_NCH-1:0] chan_req;
  input wire instr_boundary;
  input wire long_op_busy;
  input wire unconditional_branch_op;
  input wire energize_output_op;
  input wire [`PIC_AW-1:0] eom_addr;
  output reg force_valid;
  output reg [`PIC_AW-1:0] force_addr;
  output wire pc_hold;
  input wire hsel;
  input wire [31:0] haddr;
  input wire [1:0] htrans;
  input wire hwrite;
  input wire [2:0] hsize;
  input wire [31:0] hwdata;
  input wire hready;
  output wire hreadyout;
  output wire hresp;
  output reg [31:0] hrdata;
  output wire irq;

  // R15 channels 30 to 33
  localparam N = `PIC_NCH;
  localparam BUS_IDLE = 1'b0;
  localparam BUS_WDATA = 1'b1;

  // Request pins come from other domains
  reg [N-1:0] s1_reg;
  reg [N-1:0] s2_reg;
  reg [N-1:0] s3_reg;
  reg [N-1:0] lvl_reg;
  reg [N-1:0] request_received_flag;
  reg [N-1:0] in_service_flag;
  reg sys_en_reg;
  reg [`PIC_ST_W-1:0] stat_reg;
  reg [`PIC_ST_W-1:0] mask_reg;
  reg [N-1:0] safe_reg;
  reg [`PIC_AW-1:0] last_grant_reg;

  reg bus_state_reg;
  reg bus_state_next;
  reg [7:0] wr_off_reg;
  wire wr_pend;

  reg [N-1:0] rr_next;
  reg [N-1:0] is_next;
  reg sys_en_next;
  reg [`PIC_ST_W-1:0] mask_next;
  reg [N-1:0] safe_next;
  reg [`PIC_ST_W-1:0] stat_next;
  reg [`PIC_ST_W-1:0] stat_evt;
  reg [N-1:0] reject_evt;
  reg [`PIC_AW-1:0] last_grant_next;
  reg [31:0] hrdata_next;
  wire [N-1:0] sync_agree;
  wire [N-1:0] ch_enabled;
  wire core_ready;

  wire [N-1:0] lvl_next;
  wire [N-1:0] req_edge;
  reg [N-1:0] grant_oh;
  reg [N-1:0] ret_oh;
  reg [`PIC_AW-1:0] grant_num;
  reg blocked;
  wire any_grant;
  wire rd_stat;
  wire rd_take;
  wire addr_take;
  integer i;

  // Index of a channel to its vector location
  function [`PIC_AW-1:0] chan_loc;
    input integer idx;
    begin
      chan_loc = `PIC_CH_BASE + idx[`PIC_AW-1:0];
    end
  endfunction

  // Lowest set bit as one-hot, the highest-priority channel of a set
  function [`PIC_NCH-1:0] first_set;
    input [`PIC_NCH-1:0] vec;
    integer k;
    begin
      first_set = {`PIC_NCH{1'b0}};
      for (k = `PIC_NCH - 1; k >= 0; k = k - 1) begin
        if (vec[k]) begin
          first_set = {`PIC_NCH{1'b0}};
          first_set[k] = 1'b1;
        end
      end
    end
  endfunction

  // Write in its data phase to one register offset
  function wr_hit;
    input pend;
    input [7:0] off;
    input [7:0] target;
    begin
      wr_hit = pend && (off == target);
    end
  endfunction

  // Third and second stage must agree before a level counts
  // A glitch seen by one stage only never reaches the level
  assign sync_agree = s2_reg ~^ s3_reg;
  assign lvl_next = (sync_agree & s3_reg) | (~sync_agree & lvl_reg);
  assign req_edge = lvl_next & ~lvl_reg;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= {N{1'b0}};
      s2_reg <= {N{1'b0}};
      s3_reg <= {N{1'b0}};
      lvl_reg <= {N{1'b0}};
    end else begin
      s1_reg <= chan_req;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      lvl_reg <= lvl_next;
    end
  end

  // Core may take a vector only between instructions and not mid-shift
  assign core_ready = instr_boundary && !long_op_busy;
  assign ch_enabled = {N{sys_en_reg}} | safe_reg;

  // Scan from highest priority downward; an active channel blocks all below
  always @* begin
    grant_oh = {N{1'b0}};
    grant_num = {`PIC_AW{1'b0}};
    blocked = 1'b0;
    for (i = 0; i < N; i = i + 1) begin
      // R14 fixed priority
      if (!blocked && request_received_flag[i]) begin
        blocked = 1'b1;
        // R17 grant only below actives
        // R3 hold while busy or disabled
        // R10 safety bypasses disable
        if (!in_service_flag[i] && core_ready && ch_enabled[i]) begin
          grant_oh[i] = 1'b1;
          grant_num = chan_loc(i);
        end
      end
    end
  end

  assign any_grant = |grant_oh;

  // R13 clear highest active
  always @* begin
    ret_oh = first_set(in_service_flag);
    if (!unconditional_branch_op) begin
      ret_oh = {N{1'b0}};
    end
  end

  // Next flag values; start overrides every other event
  always @* begin
    rr_next = request_received_flag;
    is_next = in_service_flag;
    if (start) begin
      // R9 start clears all
      rr_next = {N{1'b0}};
      is_next = {N{1'b0}};
    end else begin
      // R1 R2 clear both together
      // R8 new edges ignored when active
      // R4 edge latched until serviced
      rr_next = (request_received_flag & ~ret_oh) |
        (req_edge & ~in_service_flag);
      // R6 nested activation
      // R7 older actives kept set
      is_next = (in_service_flag & ~ret_oh) | grant_oh;
    end
    // Guard: in-service alone is never a legal pair
    is_next = is_next & rr_next;
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      request_received_flag <= {N{1'b0}};
      in_service_flag <= {N{1'b0}};
    end else begin
      request_received_flag <= rr_next;
      in_service_flag <= is_next;
    end
  end

  // R11 forced vector to core
  // R12 program counter held
  always @* begin
    force_valid = any_grant && !start;
    force_addr = grant_num;
  end
  assign pc_hold = force_valid;

  // AHB-Lite slave, zero wait states
  assign hreadyout = 1'b1;
  assign hresp = `PIC_HRESP_OKAY;
  assign addr_take = hsel && hready && htrans[1];
  assign rd_take = addr_take && !hwrite;
  assign rd_stat = rd_take && (haddr[7:0] == `PIC_OFF_STAT);

  // Data phase tracker: a write lands one cycle after its address
  always @* begin
    case (bus_state_reg)
      BUS_IDLE: begin
        bus_state_next = (addr_take && hwrite) ? BUS_WDATA : BUS_IDLE;
      end
      BUS_WDATA: begin
        bus_state_next = (addr_take && hwrite) ? BUS_WDATA : BUS_IDLE;
      end
      default: begin
        bus_state_next = BUS_IDLE;
      end
    endcase
  end

  assign wr_pend = (bus_state_reg == BUS_WDATA);

  // Read word chosen in the address phase, shown in the data phase
  always @* begin
    hrdata_next = hrdata;
    if (rd_take) begin
      case (haddr[7:0])
        `PIC_OFF_CTRL: hrdata_next = {31'h0000_0000, sys_en_reg};
        `PIC_OFF_STATE: hrdata_next = {{(32-2*N){1'b0}},
                                       in_service_flag,
                                       request_received_flag};
        `PIC_OFF_STAT: hrdata_next = {{(32-`PIC_ST_W){1'b0}}, stat_reg};
        `PIC_OFF_MASK: hrdata_next = {{(32-`PIC_ST_W){1'b0}}, mask_reg};
        `PIC_OFF_SAFE: hrdata_next = {{(32-N){1'b0}}, safe_reg};
        `PIC_OFF_GRANT: begin
          hrdata_next = {{(32-`PIC_AW){1'b0}}, last_grant_reg};
        end
        default: hrdata_next = 32'h0000_0000;
      endcase
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_state_reg <= BUS_IDLE;
      wr_off_reg <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else begin
      bus_state_reg <= bus_state_next;
      wr_off_reg <= haddr[7:0];
      hrdata <= hrdata_next;
    end
  end

  // Energize-output codes and software both steer the enable
  // The core's codes come last so they win over a same-cycle bus write
  always @* begin
    sys_en_next = sys_en_reg;
    mask_next = mask_reg;
    safe_next = safe_reg;
    if (wr_hit(wr_pend, wr_off_reg, `PIC_OFF_CTRL)) begin
      sys_en_next = hwdata[`PIC_CTRL_EN_BIT];
    end
    // R10 energize-output disable
    if (energize_output_op && eom_addr == `PIC_EOM_DISABLE) begin
      sys_en_next = 1'b0;
    end
    // R5 re-enable releases waiting
    if (energize_output_op && eom_addr == `PIC_EOM_ENABLE) begin
      sys_en_next = 1'b1;
    end
    if (wr_hit(wr_pend, wr_off_reg, `PIC_OFF_MASK)) begin
      mask_next = hwdata[`PIC_ST_W-1:0];
    end
    if (wr_hit(wr_pend, wr_off_reg, `PIC_OFF_SAFE)) begin
      safe_next = hwdata[N-1:0];
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_en_reg <= `PIC_CTRL_RST;
      mask_reg <= `PIC_MASK_RST;
      safe_reg <= `PIC_SAFE_RST;
    end else begin
      sys_en_reg <= sys_en_next;
      mask_reg <= mask_next;
      safe_reg <= safe_next;
    end
  end

  // Sticky events; a set in the clearing cycle survives the read
  always @* begin
    reject_evt = req_edge & in_service_flag;
    stat_evt = {|reject_evt, |ret_oh, force_valid};
    stat_next = (rd_stat ? {`PIC_ST_W{1'b0}} : stat_reg) | stat_evt;
    last_grant_next = last_grant_reg;
    if (force_valid) begin
      last_grant_next = grant_num;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_reg <= {`PIC_ST_W{1'b0}};
      last_grant_reg <= {`PIC_AW{1'b0}};
    end else begin
      stat_reg <= stat_next;
      last_grant_reg <= last_grant_next;
    end
  end

  assign irq = |(stat_reg & mask_reg);

endmodule // pic_channels

// File: tb/pic_chk.sv
// Assertion checker on the interrupt channel block ports
`timescale 1ns/1ps
`include "pic_map.vh"
module pic_chk (
  input wire clk,
  input wire rst_n,
  input wire start,
  input wire instr_boundary,
  input wire long_op_busy,
  input wire unconditional_branch_op,
  input wire force_valid,
  input wire [`PIC_AW-1:0] force_addr,
  input wire pc_hold,
  input wire hreadyout,
  input wire hresp
);
  logic [`PIC_AW-1:0] last_g;
  logic cleared;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Same channel may only be granted again after a return or start
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_g <= '0;
      cleared <= 1'b1;
    end else begin
      if (force_valid)
        last_g <= force_addr;
      cleared <= !force_valid & (cleared | unconditional_branch_op | start);
    end
  end
  property p_pc; pc_hold == force_valid; endproperty
  a_pc: assert property (p_pc)
    else $error("pc_hold differs from force_valid");
  property p_bnd; force_valid |-> instr_boundary; endproperty
  a_bnd: assert property (p_bnd)
    else $error("grant outside an instruction boundary");
  property p_long; force_valid |-> !long_op_busy; endproperty
  a_long: assert property (p_long)
    else $error("grant during a long operation");
  property p_start; start |-> !force_valid; endproperty
  a_start: assert property (p_start)
    else $error("grant while start is held");
  property p_chan; force_valid |-> force_addr inside {[30:33]}; endproperty
  a_chan: assert property (p_chan)
    else $error("vector outside the fitted channels");
  property p_nest;
    force_valid ##1 force_valid |-> force_addr < $past(force_addr);
  endproperty
  a_nest: assert property (p_nest)
    else $error("back to back grant not of higher priority");
  property p_once; force_valid && force_addr == last_g |-> cleared; endproperty
  a_once: assert property (p_once)
    else $error("active channel granted again");
  property p_bus; hreadyout && !hresp; endproperty
  a_bus: assert property (p_bus)
    else $error("bus slave not ready or not okay");
endmodule // pic_chk

// File: tb/pic_core_model.sv
// Core sequencer model: boundaries, stalls and vector capture
`timescale 1ns/1ps
module pic_core_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic stall,
  input wire logic force_valid,
  input wire logic [13:0] force_addr,
  output logic instr_boundary,
  output logic long_op_busy,
  output logic [13:0] last_vec,
  output int grants
);
  // Shift or divide stalls the boundary
  assign long_op_busy = stall;
  assign instr_boundary = !stall;
  // vector word taken once, routine returns later
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_vec <= 14'h0;
      grants <= 0;
    end else if (force_valid) begin
      last_vec <= force_addr;
      grants <= grants + 1;
    end
  end
endmodule // pic_core_model

// File: tb/priority_interrupt_channels_tb.sv
// Self-checking testbench for the interrupt channel block
`timescale 1ns/1ps
`include "pic_map.vh"
module priority_interrupt_channels_tb;
  logic clk, rst_n, start, ret, stall, hsel, hwrite, fv, pch, hro, hrs, irq;
  logic ib, lob;
  logic [3:0] req;
  logic [13:0] fa, vec;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  int num_errors = 0, comparisons = 0, ng, n0;
  logic [4:0] rows [6] = '{5'h11, 5'h12, 5'h14, 5'h18, 5'h01, 5'h02};
  pic_channels dut_u (.clk(clk), .rst_n(rst_n), .start(start),
    .chan_req(req), .instr_boundary(ib), .long_op_busy(lob),
    .unconditional_branch_op(ret), .energize_output_op(1'b0),
    .eom_addr(14'h0), .force_valid(fv), .force_addr(fa), .pc_hold(pch),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hro), .hreadyout(hro),
    .hresp(hrs), .hrdata(hrdata), .irq(irq));
  pic_core_model core_u (.clk(clk), .rst_n(rst_n), .stall(stall),
    .force_valid(fv), .force_addr(fa), .instr_boundary(ib),
    .long_op_busy(lob), .last_vec(vec), .grants(ng));
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1;
    haddr <= {24'h0, a};
    htrans <= `PIC_HTRANS_NONSEQ;
    hwrite <= w;
    @(posedge clk);
    while (!hro) @(posedge clk);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (!hro) @(posedge clk);
    rd = hrdata;
  endtask
  task pulse(input logic [3:0] r);
    n0 = ng;
    req <= r;
    // Pins must stand two edges so the last two sync stages agree
    repeat (2) @(posedge clk);
    req <= 4'h0;
    repeat (8) @(posedge clk);
  endtask
  task give_ret;
    ret <= 1;
    @(posedge clk);
    ret <= 0;
    @(posedge clk);
  endtask
  task finish_test;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #20000;
    num_errors++;
    finish_test;
  end
  initial begin
    {rst_n, start, ret, stall, hsel, hwrite, req} = '0;
    {haddr, hwdata, htrans} = '0;
    repeat (3) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    foreach (rows[i]) begin
      ahb(1, `PIC_OFF_CTRL, {31'h0, rows[i][4]});
      pulse(rows[i][3:0]);
      chk("grants", {31'h0, rows[i][4] | rows[i][0]}, ng - n0);
      if (rows[i][4] | rows[i][0]) begin
        chk("vector", 30 + $clog2(rows[i][3:0]), {18'h0, vec});
        give_ret;
      end
    end
    ahb(1, `PIC_OFF_CTRL, 32'h1);
    repeat (8) @(posedge clk);
    chk("resume", 32'd31, {18'h0, vec});
    give_ret;
    stall <= 1;
    pulse(4'h8);
    chk("stalled", n0, ng);
    stall <= 0;
    repeat (2) @(posedge clk);
    chk("low vector", 32'd33, {18'h0, vec});
    pulse(4'h2);
    chk("preempt", 32'd31, {18'h0, vec});
    pulse(4'h2);
    chk("repeat", n0, ng);
    ahb(0, `PIC_OFF_STATE, 32'h0);
    chk("state", 32'haa, rd);
    give_ret;
    ahb(0, `PIC_OFF_STATE, 32'h0);
    chk("state ret", 32'h88, rd);
    ahb(1, `PIC_OFF_MASK, 32'h1);
    @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    ahb(0, `PIC_OFF_STAT, 32'h0);
    chk("status", 32'h7, {29'h0, rd[2:0]});
    @(posedge clk);
    chk("irq clr", 32'h0, {31'h0, irq});
    ahb(0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, rd);
    start <= 1;
    repeat (2) @(posedge clk);
    start <= 0;
    ahb(0, `PIC_OFF_STATE, 32'h0);
    chk("start", 32'h0, rd);
    finish_test;
  end
endmodule // priority_interrupt_channels_tb
bind pic_channels pic_chk chk_u (.clk(clk), .rst_n(rst_n), .start(start),
  .instr_boundary(instr_boundary), .long_op_busy(long_op_busy),
  .unconditional_branch_op(unconditional_branch_op),
  .force_valid(force_valid), .force_addr(force_addr), .pc_hold(pc_hold),
  .hreadyout(hreadyout), .hresp(hresp));
